/* inc/numconv_defs.svh */
`ifndef NUMCONV_DEFS_SVH
`define NUMCONV_DEFS_SVH
`define WORD_W 16
`define REAL_W 32
`define SIGN_BIT 15
`define MAG_MSB 14
`define NIB_W 4
`define NIB_COUNT 4
`define BCD_MAX_DIGIT 4'h9
`define DEC_RADIX 16'h000A
`define BIN_BCD_MAX 16'h270F
`define MAG_MAX 16'h7FFF
`define TC_MIN 16'h8000
`define REAL_SIGN 31
`define EXP_MSB 30
`define EXP_LSB 23
`define FRAC_MSB 22
`define EXP_BIAS 8'h7F
`define EXP_BIAS_MAX 8'h8E
`define OCT_DIGIT_W 3
`define OCT_COUNT 6
`define ZERO16 16'h0000
`define ZERO32 32'h00000000
`define ONE16 16'h0001
`endif

/* inc/numconv_pkg.sv */
package numconv_pkg;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_BCD_TO_BIN = 4'h1,
		OP_BIN_TO_BCD = 4'h2,
		OP_BIN_TO_REAL = 4'h3,
		OP_SM_TO_TC = 4'h4,
		OP_TC_TO_SM = 4'h5,
		OP_NEGATE_TC = 4'h6,
		OP_BIN_TO_OCT = 4'h7,
		OP_CHECK_BCD = 4'h8,
		OP_DEFAULT_VIEW = 4'h9
	} op_type;
endpackage

/* design/number_format_converter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "numconv_defs.svh"
module number_format_converter
	import numconv_pkg::*;
(
	// Clock and reset.
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// Request.
	input wire logic REQ_I,
	input wire op_type OP_I,
	input wire logic [`WORD_W-1:0] DATA_I,
	input wire logic VIEW_BIN_I,
	// Result.
	output logic VALID_O,
	output logic [`REAL_W-1:0] RESULT_O,
	output logic INVALID_DIGIT_O,
	output logic OVERFLOW_O,
	output logic DONE_O
);
	typedef struct packed {
		logic valid;
		logic [`REAL_W-1:0] result;
		logic invalid_digit;
		logic overflow;
		logic done;
	} state_type;

	state_type state_reg;
	state_type state_next;

	function automatic logic bcd_bad(input logic [`WORD_W-1:0] w);
		logic bad;
		bad = 1'b0;
		for (int i = 0; i < `NIB_COUNT; i++) begin
			if (w[i*`NIB_W +: `NIB_W] > `BCD_MAX_DIGIT) begin
				bad = 1'b1;
			end
		end
		return bad;
	endfunction

	// Horner accumulation keeps this to shifts and adds; the accumulated value never exceeds 9999.
	function automatic logic [`WORD_W-1:0] bcd_to_bin(input logic [`WORD_W-1:0] w);
		logic [`WORD_W-1:0] acc;
		acc = `ZERO16;
		for (int i = `NIB_COUNT-1; i >= 0; i--) begin
			acc = 16'((acc << 3) + (acc << 1) + {12'h000, w[i*`NIB_W +: `NIB_W]});
		end
		return acc;
	endfunction

	// Double-dabble: shift in one binary bit at a time, adjust each digit above four.
	function automatic logic [`WORD_W-1:0] bin_to_bcd(input logic [`WORD_W-1:0] v);
		logic [`WORD_W-1:0] bcd;
		bcd = `ZERO16;
		for (int b = `WORD_W-1; b >= 0; b--) begin
			for (int d = 0; d < `NIB_COUNT; d++) begin
				if (bcd[d*`NIB_W +: `NIB_W] > 4'h4) begin
					bcd[d*`NIB_W +: `NIB_W] = 4'(bcd[d*`NIB_W +: `NIB_W] + 4'h3);
				end
			end
			bcd = {bcd[`WORD_W-2:0], v[b]};
		end
		return bcd;
	endfunction

	function automatic logic [`WORD_W-1:0] negate_tc(input logic [`WORD_W-1:0] v);
		return 16'(~v + `ONE16);
	endfunction

	// Exact conversion: sixteen bits always fit the twenty-three bit fraction.
	function automatic logic [`REAL_W-1:0] bin_to_real(input logic [`WORD_W-1:0] v);
		logic [`REAL_W-1:0] r;
		logic [`WORD_W-1:0] norm;
		logic [7:0] exp;
		r = `ZERO32;
		norm = v;
		exp = `EXP_BIAS_MAX;
		if (v != `ZERO16) begin
			for (int i = 0; i < `WORD_W; i++) begin
				if (!norm[`WORD_W-1]) begin
					norm = norm << 1;
					exp = 8'(exp - 8'h01);
				end
			end
			r[`REAL_SIGN] = 1'b0;
			r[`EXP_MSB:`EXP_LSB] = exp;
			r[`FRAC_MSB -: `WORD_W-1] = norm[`WORD_W-2:0];
		end
		return r;
	endfunction

	function automatic logic [`REAL_W-1:0] bin_to_oct(input logic [`WORD_W-1:0] v);
		logic [`REAL_W-1:0] o;
		logic [`OCT_DIGIT_W*`OCT_COUNT-1:0] ext;
		o = `ZERO32;
		ext = {2'b00, v};
		for (int i = 0; i < `OCT_COUNT; i++) begin
			o[i*`NIB_W +: `NIB_W] = {1'b0, ext[i*`OCT_DIGIT_W +: `OCT_DIGIT_W]};
		end
		return o;
	endfunction

	always_comb begin
		state_next = state_reg;
		state_next.valid = 1'b0;
		state_next.done = 1'b0;
		if (REQ_I) begin
			state_next.done = 1'b1;
			state_next.valid = 1'b1;
			state_next.invalid_digit = 1'b0;
			state_next.overflow = 1'b0;
			state_next.result = `ZERO32;
			unique case (OP_I)
				OP_BCD_TO_BIN: begin
					if (bcd_bad(DATA_I)) begin
						state_next.invalid_digit = 1'b1;
						state_next.valid = 1'b0;
					end else begin
						state_next.result = {16'h0000, bcd_to_bin(DATA_I)};
					end
				end
				OP_BIN_TO_BCD: begin
					if (DATA_I > `BIN_BCD_MAX) begin
						state_next.overflow = 1'b1;
						state_next.valid = 1'b0;
					end else begin
						state_next.result = {16'h0000, bin_to_bcd(DATA_I)};
					end
				end
				OP_BIN_TO_REAL: begin
					state_next.result = bin_to_real(DATA_I);
				end
				OP_SM_TO_TC: begin
					// Negative zero in sign-magnitude maps to plain zero.
					if (DATA_I[`SIGN_BIT]) begin
						state_next.result = {16'h0000, negate_tc({1'b0, DATA_I[`MAG_MSB:0]})};
					end else begin
						state_next.result = {16'h0000, DATA_I};
					end
				end
				OP_TC_TO_SM: begin
					if (DATA_I == `TC_MIN) begin
						state_next.overflow = 1'b1;
						state_next.valid = 1'b0;
					end else if (DATA_I[`SIGN_BIT]) begin
						state_next.result = {16'h0000, 1'b1, 15'(negate_tc(DATA_I))};
					end else begin
						state_next.result = {16'h0000, DATA_I};
					end
				end
				OP_NEGATE_TC: begin
					if (DATA_I == `TC_MIN) begin
						state_next.overflow = 1'b1;
						state_next.valid = 1'b0;
					end else begin
						state_next.result = {16'h0000, negate_tc(DATA_I)};
					end
				end
				OP_BIN_TO_OCT: begin
					state_next.result = bin_to_oct(DATA_I);
				end
				OP_CHECK_BCD: begin
					// A word with a bad digit is refused like any other, so no stale echo reaches the reader.
					if (bcd_bad(DATA_I)) begin
						state_next.invalid_digit = 1'b1;
						state_next.valid = 1'b0;
					end else begin
						state_next.result = {16'h0000, DATA_I};
					end
				end
				OP_DEFAULT_VIEW: begin
					// Timer and counter words are stored as BCD; binary view decodes them.
					if (!VIEW_BIN_I) begin
						state_next.result = {16'h0000, DATA_I};
					end else if (bcd_bad(DATA_I)) begin
						state_next.invalid_digit = 1'b1;
						state_next.valid = 1'b0;
					end else begin
						state_next.result = {16'h0000, bcd_to_bin(DATA_I)};
					end
				end
				default: begin
					state_next.valid = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign VALID_O = state_reg.valid;
	assign RESULT_O = state_reg.result;
	assign INVALID_DIGIT_O = state_reg.invalid_digit;
	assign OVERFLOW_O = state_reg.overflow;
	assign DONE_O = state_reg.done;
endmodule
`default_nettype wire

/* bench/number_format_converter_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module nfc_checker
	import numconv_pkg::*;
(
	// Request side.
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic REQ_I,
	input wire op_type OP_I,
	input wire logic [15:0] DATA_I,
	input wire logic VIEW_BIN_I,
	// Result side.
	input wire logic VALID_O,
	input wire logic [31:0] RESULT_O,
	input wire logic INVALID_DIGIT_O,
	input wire logic OVERFLOW_O,
	input wire logic DONE_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	AST_DONE: assert property (REQ_I |=> DONE_O) else $error("done missing");
	AST_IDLE: assert property (!REQ_I |=> !DONE_O && !VALID_O && $stable(RESULT_O)) else $error("idle change");
	AST_GOOD: assert property (VALID_O |-> DONE_O && !INVALID_DIGIT_O && !OVERFLOW_O) else $error("bad valid");
	AST_DIGIT: assert property (REQ_I && OP_I == OP_CHECK_BCD && DATA_I[3:0] > 4'h9
		|=> INVALID_DIGIT_O && !VALID_O) else $error("digit not flagged");
	AST_TEN: assert property (REQ_I && OP_I == OP_BIN_TO_BCD && DATA_I == 16'h000A
		|=> RESULT_O == 32'h00000010) else $error("ten wrong");
	AST_RANGE: assert property (REQ_I && OP_I == OP_BIN_TO_BCD && DATA_I > 16'h270F
		|=> OVERFLOW_O && RESULT_O == 32'h00000000) else $error("range");
	AST_NEG: assert property (REQ_I && OP_I == OP_NEGATE_TC && DATA_I != 16'h8000
		|=> RESULT_O[15:0] == ~$past(DATA_I) + 16'h0001) else $error("negate");
	AST_SM: assert property (REQ_I && OP_I == OP_SM_TO_TC && DATA_I[15]
		|=> RESULT_O[15:0] == ~($past(DATA_I) & 16'h7FFF) + 16'h0001) else $error("sign");
endmodule
bind number_format_converter nfc_checker u_chk (.*);
`default_nettype wire

/* bench/nfc_cpu.sv */
`timescale 1ns/10ps
`default_nettype none
module nfc_cpu
	import numconv_pkg::*;
(
	// Clock.
	input wire logic clk_i,
	// Request.
	output logic req_o,
	output op_type op_o,
	output logic [15:0] data_o,
	output logic view_o
);
	initial begin
		req_o = 1'b0;
		op_o = OP_NONE;
		data_o = 16'h0000;
		view_o = 1'b0;
	end
	// Operation and operand move together, so one request never mixes data types.
	task automatic issue(input logic r, input op_type o, input logic [15:0] d, input logic v);
		@(posedge clk_i);
		req_o <= r;
		op_o <= o;
		data_o <= d;
		view_o <= v;
	endtask
endmodule
`default_nettype wire

/* bench/tb_number_format_converter.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_number_format_converter;
	import numconv_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req, view, valid, inv, ovf, done;
	op_type op, o;
	logic [15:0] data;
	logic [31:0] result, t;
	logic [35:0] exp_v = 36'h000000000;
	int err_total = 0;
	int total_checks = 0;
	int unsigned seed = 36;
	logic [20:0] dir [20] = '{21'h02000A, 21'h02270F, 21'h022710, 21'h010010, 21'h014095, 21'h01409A,
		21'h080009, 21'h08000A, 21'h0A0000, 21'h030000, 21'h03FFFF, 21'h048064, 21'h048000, 21'h05FF9C,
		21'h058000, 21'h068000, 21'h060064, 21'h07FFFF, 21'h091234, 21'h191234};
	always #2.5 clk = ~clk;
	nfc_cpu u_cpu (.clk_i(clk), .req_o(req), .op_o(op), .data_o(data), .view_o(view));
	number_format_converter u_dut (.CORE_CLK_I(clk), .RST_I(rst), .REQ_I(req), .OP_I(op), .DATA_I(data),
		.VIEW_BIN_I(view), .VALID_O(valid), .RESULT_O(result), .INVALID_DIGIT_O(inv), .OVERFLOW_O(ovf), .DONE_O(done));
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [35:0] model(op_type m, logic [15:0] d, logic v);
		logic b, bad, ov, ok;
		int n, e;
		logic [31:0] r;
		b = 0; bad = 0; ov = 0; ok = 1; n = 0; e = 0; r = 0;
		for (int i = 3; i >= 0; i--) begin
			b |= d[i*4+:4] > 4'h9;
			n = n * 10 + d[i*4+:4];
		end
		case (m)
			OP_BCD_TO_BIN: begin bad = b; r = n; end
			OP_CHECK_BCD: begin bad = b; r = d; end
			OP_DEFAULT_VIEW: r = v ? n : d;
			OP_BIN_TO_BCD: begin ov = d > 16'h270F; r = d / 1000 << 12 | d / 100 % 10 << 8 | d / 10 % 10 << 4 | d % 10; end
			OP_BIN_TO_REAL: if (d != 0) begin
				for (int i = 0; i < 16; i++) if (d[i]) e = i;
				r = (127 + e) << 23 | (int'(d) << (23 - e)) & 32'h007FFFFF;
			end
			OP_SM_TO_TC: r = d[15] ? 16'(~(d & 16'h7FFF) + 16'h0001) : d;
			OP_TC_TO_SM: begin ov = d == 16'h8000; r = d[15] ? {1'b1, 15'(-d)} : d; end
			OP_NEGATE_TC: begin ov = d == 16'h8000; r = 16'(~d + 16'h0001); end
			OP_BIN_TO_OCT: for (int i = 0; i < 6; i++) r |= ((d >> 3 * i) & 7) << 4 * i;
			default: ok = 0;
		endcase
		if (bad || ov) r = 0;
		return {1'b1, ok && !bad && !ov, bad, ov, r};
	endfunction
	task chk(logic [35:0] got, logic [35:0] want);
		total_checks++;
		if (got !== want) begin
			err_total++;
			$display("FAIL %0t: got %h want %h", $time, got, want);
		end
	endtask
	// The check in each step judges the request of the step before, so requests run back to back.
	task step(logic r, op_type m, logic [15:0] d, logic v);
		u_cpu.issue(r, m, d, v);
		#1 chk({done, valid, inv, ovf, result}, exp_v);
		exp_v = r ? model(m, d, v) : {2'b00, exp_v[33:0]};
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (dir[i]) step(1'b1, op_type'(dir[i][19:16]), dir[i][15:0], dir[i][20]);
		step(1'b1, OP_BCD_TO_BIN, 16'h0867, 1'b0);
		step(1'b1, OP_BIN_TO_REAL, 16'd867, 1'b0);
		repeat (400) begin
			t = rnd();
			o = op_type'(t[3:0]);
			// View data is kept to legal digits, since the model does not judge digits in the binary view.
			step(t[4], o, o == OP_DEFAULT_VIEW ? t[31:16] & 16'h7777 : t[31:16], t[5]);
		end
		step(1'b0, OP_NONE, 16'h0000, 1'b0);
		stop_test;
	end
	initial begin
		#20000;
		err_total++;
		stop_test;
	end
endmodule
`default_nettype wire
